/* File: usm_port.sv */
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
// Overview of operation
// [RULE1] Load shifter only after previous last bit left
// [RULE2] Transfer in one cycle, flag buffer empty
// [RULE3] Buffer-empty flag ignores enable, cleared by write; the code gates the flag with transmit enable
// [RULE4] Read-only shifter-empty status bit
// [RULE5] Transmit enable arms; shifting needs buffered data
// [RULE6] Drive bit on clock rise, stable at fall
// [RULE7] Baud generator held reset while all enables clear
// [RULE8] Clearing transmit enable aborts and floats pins
// [RULE9] Receive enable aborts transmit, floats data pin; the code only pauses the shifter, which resumes when reception ends
// [RULE10] Single reception ends clearing its enable itself
// [RULE11] Ninth transmit bit latched at transfer
// [RULE12] Software writes ninth bit before buffer
// [RULE13] Receive enables; sample data on falling edge
// [RULE14] Single word or continuous; continuous wins
// [RULE15] Word to FIFO, receive-full flag until empty
// [RULE16] Two-deep FIFO, third word overruns and drops
// [RULE17] Overrun blocks pushes, cleared by continuous clear
// [RULE18] Ninth received bit queued with each word
// [RULE19] Software reads control before received byte
// [RULE20] Software transmit setup order
// [RULE21] Software receive setup with enables clear first
// [RULE22] Interrupt enables gate flags onto interrupt
// [RULE23] Clock-source clear selects slave, external clock
// [RULE24] Sync select plus port enable claims pins
// [RULE25] Master drives shift clock on clock line
// [RULE26] Shift clock period from baud divisor
module usm_port
    import usm_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input usm_bus_req_t bus_i,
    output logic [7:0] rd_data_o,
    input wire logic shift_clock_line_i,
    output logic shift_clock_line_o,
    output logic shift_clock_line_oe_o,
    input wire logic serial_data_line_i,
    output logic serial_data_line_o,
    output logic serial_data_line_oe_o,
    output logic irq_o
);

    // ------------------------------------------------------------------
    // State.
    // ------------------------------------------------------------------
    logic [7:0] transmit_buffer;
    logic [7:0] baud_divisor;
    logic [7:0] interrupt_enables;
    logic [7:0] rd_data;
    logic clock_source_select;
    logic tx_ninth_bit_enable;
    logic transmit_enable;
    logic sync_select;
    logic tx_ninth_bit;
    logic port_enable;
    logic rx_ninth_bit_enable;
    logic single_receive_enable;
    logic continuous_receive_enable;
    logic overrun_error;
    logic tx_full;
    logic [8:0] transmit_shifter;
    logic [3:0] tx_left;
    logic tx_last;
    logic data_out;
    logic [8:0] receive_shifter;
    logic [3:0] rx_got;
    logic [8:0] receive_fifo [2];
    logic [1:0] fifo_cnt;
    logic fifo_head;
    logic [7:0] brg_cnt;
    logic ck_int;
    logic [1:0] sy1;
    logic [1:0] sy2;
    logic [1:0] sy3;
    logic [1:0] lvl;

    // ------------------------------------------------------------------
    // Address decode.
    // ------------------------------------------------------------------
    wire wr_rx_ctrl = bus_i.wr && bus_i.addr == USM_ADDR_RX_CTRL;
    wire wr_tx_ctrl = bus_i.wr && bus_i.addr == USM_ADDR_TX_CTRL;
    wire wr_tx_buf = bus_i.wr && bus_i.addr == USM_ADDR_TX_BUF;
    wire wr_enables = bus_i.wr && bus_i.addr == USM_ADDR_ENABLES;
    wire wr_baud = bus_i.wr && bus_i.addr == USM_ADDR_BAUD;
    wire rd_rx_fifo = bus_i.rd && bus_i.addr == USM_ADDR_RX_FIFO;

    // ------------------------------------------------------------------
    // Pin input filtering and mode decode.
    // ------------------------------------------------------------------
    // A level is accepted only once the second and third stages agree.
    wire [1:0] sy_diff = sy2 ^ sy3;
    wire [1:0] next_lvl = (~sy_diff & sy3) | (sy_diff & lvl);
    wire ext_rise = next_lvl[0] & ~lvl[0];
    wire ext_fall = ~next_lvl[0] & lvl[0];
    wire din = lvl[1];

    wire active = port_enable & sync_select; // RULE24
    wire rx_mode = active & (continuous_receive_enable | single_receive_enable); // RULE13
    wire tx_mode = active & transmit_enable & ~rx_mode; // RULE9
    wire brg_run = transmit_enable | continuous_receive_enable | single_receive_enable;
    wire brg_wrap = brg_cnt == baud_divisor; // RULE26

    // Edges come from the baud generator in master mode, from the pin otherwise.
    wire tick_rise = clock_source_select ? (brg_run & brg_wrap & ~ck_int) : ext_rise; // RULE23
    wire tick_fall = clock_source_select ? (brg_run & brg_wrap & ck_int) : ext_fall; // RULE23

    // ------------------------------------------------------------------
    // Transmit control terms.
    // ------------------------------------------------------------------
    wire [3:0] tx_bits = tx_ninth_bit_enable ? USM_BITS_9 : USM_BITS_8;
    wire tx_busy = (tx_left != 4'h0) | tx_last;
    wire shifter_empty_status = ~tx_busy; // RULE4
    wire tx_load = transmit_enable & tx_full & ~tx_busy; // RULE1 RULE5
    wire tx_shift = tx_mode & tick_rise & (tx_left != 4'h0); // RULE6
    wire tx_end = tx_mode & tick_fall & tx_last & (tx_left == 4'h0);
    wire tx_buffer_empty_flag = transmit_enable & ~tx_full; // RULE3

    // ------------------------------------------------------------------
    // Receive control terms.
    // ------------------------------------------------------------------
    wire [3:0] rx_bits = rx_ninth_bit_enable ? USM_BITS_9 : USM_BITS_8;
    wire rx_sample = rx_mode & tick_fall; // RULE13
    wire rx_done = rx_sample & (rx_got == rx_bits - 4'h1);
    wire rx_push = rx_done & ~overrun_error & (fifo_cnt != USM_FIFO_DEPTH); // RULE15 RULE17
    wire rx_overflow = rx_done & ~overrun_error & (fifo_cnt == USM_FIFO_DEPTH); // RULE16
    wire fifo_pop = rd_rx_fifo & (fifo_cnt != 2'h0);
    wire fifo_wr_idx = fifo_head ^ fifo_cnt[0];
    wire [8:0] rx_word = rx_ninth_bit_enable ? {din, receive_shifter[8:1]}
                                             : {1'b0, din, receive_shifter[8:2]};
    wire receive_full_flag = fifo_cnt != 2'h0; // RULE15
    wire [8:0] fifo_front = receive_fifo[fifo_head];
    wire rx_ninth_bit = fifo_front[8]; // RULE18

    // ------------------------------------------------------------------
    // Register read view.
    // ------------------------------------------------------------------
    wire [7:0] flags_view = {2'h0, receive_full_flag, tx_buffer_empty_flag, 4'h0};
    wire [7:0] rx_ctrl_view = {port_enable, rx_ninth_bit_enable, single_receive_enable,
                               continuous_receive_enable, 2'h0, overrun_error, rx_ninth_bit};
    wire [7:0] tx_ctrl_view = {clock_source_select, tx_ninth_bit_enable, transmit_enable,
                               sync_select, 2'h0, shifter_empty_status, tx_ninth_bit};
    wire [7:0] next_rd_data =
        (bus_i.addr == USM_ADDR_FLAGS) ? flags_view :
        (bus_i.addr == USM_ADDR_RX_CTRL) ? rx_ctrl_view :
        (bus_i.addr == USM_ADDR_TX_BUF) ? transmit_buffer :
        (bus_i.addr == USM_ADDR_RX_FIFO) ? fifo_front[7:0] :
        (bus_i.addr == USM_ADDR_ENABLES) ? interrupt_enables :
        (bus_i.addr == USM_ADDR_TX_CTRL) ? tx_ctrl_view :
        (bus_i.addr == USM_ADDR_BAUD) ? baud_divisor : USM_RST_BYTE;

    // ------------------------------------------------------------------
    // Outputs.
    // ------------------------------------------------------------------
    assign rd_data_o = rd_data;
    assign shift_clock_line_o = ck_int;
    assign shift_clock_line_oe_o = active & clock_source_select & brg_run; // RULE25 RULE8
    assign serial_data_line_o = data_out;
    assign serial_data_line_oe_o = tx_mode; // RULE8 RULE9 RULE10
    // The flags set on their own; the enables only gate the request.
    assign irq_o = (tx_buffer_empty_flag & interrupt_enables[USM_FLG_TX_EMPTY])
                 | (receive_full_flag & interrupt_enables[USM_FLG_RX_FULL]); // RULE22

    // ------------------------------------------------------------------
    // Register bus.
    // ------------------------------------------------------------------
    // Read data stands in the cycle after the strobe.
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            rd_data <= USM_RST_BYTE;
        end else if (bus_i.rd) begin
            rd_data <= next_rd_data;
        end
    end

    // Plain software-owned bytes.
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            baud_divisor <= USM_RST_BYTE;
            interrupt_enables <= USM_RST_BYTE;
        end else begin
            if (wr_baud) baud_divisor <= bus_i.wdata;
            if (wr_enables) interrupt_enables <= bus_i.wdata;
        end
    end

    // Transmit control; the shifter-empty bit is not stored.
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            {clock_source_select, tx_ninth_bit_enable, transmit_enable, sync_select} <=
                USM_TX_CTRL_RST[7:4];
            tx_ninth_bit <= USM_TX_CTRL_RST[USM_TXC_NINTH];
        end else if (wr_tx_ctrl) begin
            clock_source_select <= bus_i.wdata[USM_TXC_CLK_SRC];
            tx_ninth_bit_enable <= bus_i.wdata[USM_TXC_NINTH_EN];
            transmit_enable <= bus_i.wdata[USM_TXC_TX_EN];
            sync_select <= bus_i.wdata[USM_TXC_SYNC];
            tx_ninth_bit <= bus_i.wdata[USM_TXC_NINTH];
        end
    end

    // Receive control; a finished single word drops its own enable unless
    // continuous reception is also on, which keeps the receiver running.
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            port_enable <= 1'b0;
            rx_ninth_bit_enable <= 1'b0;
            single_receive_enable <= 1'b0;
            continuous_receive_enable <= 1'b0;
        end else if (wr_rx_ctrl) begin
            port_enable <= bus_i.wdata[USM_RXC_PORT_EN];
            rx_ninth_bit_enable <= bus_i.wdata[USM_RXC_NINTH_EN];
            single_receive_enable <= bus_i.wdata[USM_RXC_SINGLE];
            continuous_receive_enable <= bus_i.wdata[USM_RXC_CONT];
        end else if (rx_done && !continuous_receive_enable) begin
            single_receive_enable <= 1'b0; // RULE10 RULE14
        end
    end

    // Overrun sets ahead of any clear in the same cycle.
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            overrun_error <= 1'b0;
        end else if (rx_overflow) begin
            overrun_error <= 1'b1; // RULE16
        end else if (!continuous_receive_enable) begin
            overrun_error <= 1'b0; // RULE17
        end
    end

    // ------------------------------------------------------------------
    // Transmit buffer and shifter.
    // ------------------------------------------------------------------
    // A write in the transfer cycle wins, so fresh data is never lost.
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            transmit_buffer <= USM_RST_BYTE;
            tx_full <= 1'b0;
        end else if (wr_tx_buf) begin
            transmit_buffer <= bus_i.wdata;
            tx_full <= 1'b1; // RULE3
        end else if (tx_load) begin
            tx_full <= 1'b0; // RULE2
        end
    end

    // The last bit is held until its falling edge before the shifter frees,
    // which lets the next word follow on the very next rising edge.
    always_ff @(posedge ref_clk_i) begin
        if (rst_i || !transmit_enable) begin
            tx_left <= 4'h0; // RULE8
            tx_last <= 1'b0;
            transmit_shifter <= 9'h000;
        end else if (tx_load) begin
            transmit_shifter <= {tx_ninth_bit, transmit_buffer}; // RULE11
            tx_left <= tx_bits;
            tx_last <= 1'b0;
        end else if (tx_shift) begin
            transmit_shifter <= {1'b0, transmit_shifter[8:1]};
            tx_left <= tx_left - 4'h1;
            tx_last <= tx_left == 4'h1;
        end else if (tx_end) begin
            tx_last <= 1'b0;
        end
    end

    // Data changes with the rising clock and so is settled at the fall.
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            data_out <= 1'b0;
        end else if (tx_shift) begin
            data_out <= transmit_shifter[0]; // RULE6
        end
    end

    // ------------------------------------------------------------------
    // Baud generator and pin synchronisers.
    // ------------------------------------------------------------------
    // Half period is divisor plus one cycles; a divisor under 2 outruns the
    // input filter, so slow devices need a larger value.
    always_ff @(posedge ref_clk_i) begin
        if (rst_i || !brg_run) begin
            brg_cnt <= 8'h00; // RULE7
            ck_int <= 1'b0;
        end else if (brg_wrap) begin
            brg_cnt <= 8'h00; // RULE26
            ck_int <= ~ck_int;
        end else begin
            brg_cnt <= brg_cnt + 8'h01;
        end
    end

    // Bit 0 carries the clock pin, bit 1 the data pin.
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            sy1 <= 2'h0;
            sy2 <= 2'h0;
            sy3 <= 2'h0;
            lvl <= 2'h0;
        end else begin
            sy1 <= {serial_data_line_i, shift_clock_line_i};
            sy2 <= sy1;
            sy3 <= sy2;
            lvl <= next_lvl;
        end
    end

    // ------------------------------------------------------------------
    // Receive shifter and FIFO.
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_i || !rx_mode) begin
            rx_got <= 4'h0;
            receive_shifter <= 9'h000;
        end else if (rx_sample) begin
            rx_got <= rx_done ? 4'h0 : rx_got + 4'h1; // RULE14
            receive_shifter <= {din, receive_shifter[8:1]};
        end
    end

    // Each entry keeps its ninth bit, so a pop reveals the next one's.
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            fifo_cnt <= 2'h0;
            fifo_head <= 1'b0;
            receive_fifo[0] <= 9'h000;
            receive_fifo[1] <= 9'h000;
        end else begin
            if (rx_push) receive_fifo[fifo_wr_idx] <= rx_word; // RULE18
            if (fifo_pop) fifo_head <= ~fifo_head;
            fifo_cnt <= fifo_cnt + {1'b0, rx_push} - {1'b0, fifo_pop};
        end
    end

    // ------------------------------------------------------------------
    // Assertions.
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    sequence s_load;
        tx_load && !wr_tx_buf && !wr_tx_ctrl;
    endsequence

    sequence s_flag_up;
        tx_buffer_empty_flag && !shifter_empty_status;
    endsequence

    a_tx_load_flag: assert property (s_load |=> s_flag_up) // RULE2
        else $error("Buffer transfer did not raise the empty flag.");
    a_load_waits: assert property (tx_end && tx_full && !wr_tx_ctrl |=> tx_load) // RULE1
        else $error("Waiting word did not follow the last bit at once.");
    a_flag_write_clr: assert property (wr_tx_buf |=> !tx_buffer_empty_flag) // RULE3
        else $error("Buffer write did not clear the empty flag.");
    a_tx_bit_rise: assert property (tx_shift |=> data_out == $past(transmit_shifter[0])) // RULE6
        else $error("Data bit not driven on the rising edge.");
    a_brg_held: assert property (!brg_run |=> brg_cnt == 8'h00 && !ck_int) // RULE7
        else $error("Baud generator ran with all enables clear.");
    a_abort_float: assert property ($fell(transmit_enable) && !rx_mode |-> // RULE8
        !serial_data_line_oe_o && !shift_clock_line_oe_o ##1 !tx_busy)
        else $error("Transmit abort left pins driven or shifter busy.");
    a_rx_float: assert property (rx_mode |-> !serial_data_line_oe_o) // RULE9
        else $error("Data pin driven during reception.");
    a_single_ends: assert property (rx_done && !continuous_receive_enable && !wr_rx_ctrl |=> // RULE10
        !single_receive_enable)
        else $error("Single reception did not drop its enable.");
    a_overrun_set: assert property (rx_overflow && !fifo_pop |=> // RULE16
        overrun_error && fifo_cnt == 2'h2)
        else $error("Third word did not raise overrun.");
    a_overrun_block: assert property (overrun_error |-> !rx_push) // RULE17
        else $error("Push happened while overrun was set.");
    a_full_flag: assert property (fifo_pop && fifo_cnt == 2'h1 && !rx_push |=> // RULE15
        !receive_full_flag)
        else $error("Receive-full flag stayed up after the FIFO emptied.");
    a_irq_gate: assert property (interrupt_enables[USM_FLG_TX_EMPTY] == 1'b0 && // RULE22
        interrupt_enables[USM_FLG_RX_FULL] == 1'b0 |-> !irq_o)
        else $error("Interrupt raised with both enables clear.");

endmodule

/* File: usm_pkg.sv */
package usm_pkg;

    // ------------------------------------------------------------------
    // Register offsets.
    // ------------------------------------------------------------------
    localparam logic [7:0] USM_ADDR_FLAGS = 8'h0c;
    localparam logic [7:0] USM_ADDR_RX_CTRL = 8'h18;
    localparam logic [7:0] USM_ADDR_TX_BUF = 8'h19;
    localparam logic [7:0] USM_ADDR_RX_FIFO = 8'h1a;
    localparam logic [7:0] USM_ADDR_ENABLES = 8'h8c;
    localparam logic [7:0] USM_ADDR_TX_CTRL = 8'h98;
    localparam logic [7:0] USM_ADDR_BAUD = 8'h99;

    // ------------------------------------------------------------------
    // Field positions.
    // ------------------------------------------------------------------
    localparam int USM_FLG_RX_FULL = 5;
    localparam int USM_FLG_TX_EMPTY = 4;
    localparam int USM_RXC_PORT_EN = 7;
    localparam int USM_RXC_NINTH_EN = 6;
    localparam int USM_RXC_SINGLE = 5;
    localparam int USM_RXC_CONT = 4;
    localparam int USM_RXC_OVERRUN = 1;
    localparam int USM_RXC_NINTH = 0;
    localparam int USM_TXC_CLK_SRC = 7;
    localparam int USM_TXC_NINTH_EN = 6;
    localparam int USM_TXC_TX_EN = 5;
    localparam int USM_TXC_SYNC = 4;
    localparam int USM_TXC_SH_EMPTY = 1;
    localparam int USM_TXC_NINTH = 0;

    // ------------------------------------------------------------------
    // Reset values, word sizes and counts.
    // ------------------------------------------------------------------
    localparam logic [7:0] USM_RST_BYTE = 8'h00;
    localparam logic [7:0] USM_TX_CTRL_RST = 8'h02;
    localparam logic [3:0] USM_BITS_8 = 4'h8;
    localparam logic [3:0] USM_BITS_9 = 4'h9;
    localparam logic [1:0] USM_FIFO_DEPTH = 2'h2;

    // Register bus request carried as one packed group.
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } usm_bus_req_t;

endpackage

/* File: usm_far_dev.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Far-side serial device model.
// ----------------------------------------------------------------
module usm_far_dev (
    input wire logic ref_clk_i,
    input wire logic ck_i,
    input wire logic dt_i,
    input wire logic arm_i,
    input wire logic slave_i,
    input wire logic go_i,
    input wire logic clr_i,
    input wire logic [31:0] pat_i,
    output logic ck_o,
    output logic ck_oe_o,
    output logic dt_o,
    output logic dt_oe_o,
    output logic [31:0] cap_o,
    output logic [5:0] cnt_o,
    output logic [5:0] ridx_o
);
    logic ck_q;
    logic sdt;
    logic armed_rise;
    // Falls of the shared clock line capture and advance bits.
    always_ff @(posedge ref_clk_i) begin
        ck_q <= ck_i;
        if (clr_i) begin
            cnt_o <= 6'h00;
        end else if (ck_q && !ck_i) begin
            cap_o[cnt_o[4:0]] <= dt_i;
            cnt_o <= cnt_o + 6'h01;
        end
        // A fall ends a bit only after a rise seen while armed, so a fall that
        // lands with the arming is not taken for a bit nobody sampled.
        if (!arm_i) begin
            ridx_o <= 6'h00;
            armed_rise <= 1'b0;
        end else if (!ck_q && ck_i) begin
            armed_rise <= 1'b1;
        end else if (ck_q && !ck_i && armed_rise) begin
            ridx_o <= ridx_o + 6'h01;
        end
    end
    // A bit changes just after a fall, so it stands across the next one.
    assign dt_o = slave_i ? sdt : pat_i[ridx_o[4:0]];
    assign dt_oe_o = arm_i;
    assign ck_oe_o = slave_i;
    // The slave clock runs only within a frame; the line rests low between.
    initial begin
        ck_o = 1'b0;
        sdt = 1'b0;
    end
    always @(posedge go_i) begin
        #137;
        for (int i = 0; i < 8; i++) begin
            sdt = pat_i[i];
            #200 ck_o = 1'b1;
            #400 ck_o = 1'b0;
            #200;
        end
    end
endmodule

/* File: usm_port_tb.sv */
`timescale 1ns/1ps
module usm_port_tb;
    import usm_pkg::*;
    logic ref_clk_i, rst_i, ck_o, ck_oe, dt_o, dt_oe, irq, p_ck, p_ck_oe, p_dt, p_dt_oe;
    logic want, slave, go, clr, ckl, dt_last;
    usm_bus_req_t bus;
    logic [7:0] rd_data;
    logic [31:0] pat, cap;
    logic [5:0] cnt, ridx;
    int n_fail, checked, r, p;
    logic [7:0] ra [8] = '{8'h0c, 8'h18, 8'h19, 8'h1a, 8'h8c, 8'h98, 8'h99, 8'h55};
    logic [7:0] rv [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00};
    // The clock line has a pull-down, so it rests low and makes no edges when free.
    wire ck_w = ck_oe ? ck_o : (p_ck_oe ? p_ck : 1'b0);
    // A released data line shows the inverse of the level last driven on it.
    wire dt_w = dt_oe ? dt_o : (p_dt_oe ? p_dt : ~dt_last);
    always @(posedge ref_clk_i) begin
        if (dt_oe || p_dt_oe) dt_last <= (dt_w === 1'b1);
    end
    usm_port uut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .bus_i(bus), .rd_data_o(rd_data),
        .shift_clock_line_i(ck_w), .shift_clock_line_o(ck_o), .shift_clock_line_oe_o(ck_oe),
        .serial_data_line_i(dt_w), .serial_data_line_o(dt_o),
        .serial_data_line_oe_o(dt_oe), .irq_o(irq));
    usm_far_dev far (.ref_clk_i(ref_clk_i), .ck_i(ck_w), .dt_i(dt_w), .arm_i(want & ~dt_oe),
        .slave_i(slave), .go_i(go), .clr_i(clr), .pat_i(pat), .ck_o(p_ck), .ck_oe_o(p_ck_oe),
        .dt_o(p_dt), .dt_oe_o(p_dt_oe), .cap_o(cap), .cnt_o(cnt), .ridx_o(ridx));
    // 10 MHz reference clock.
    initial begin
        ref_clk_i = 1'b0;
        forever #50 ref_clk_i = ~ref_clk_i;
    end
    // ------------------------------------------------------------
    // Bus access and checking.
    // ------------------------------------------------------------
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge ref_clk_i);
        bus.wr <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk_i);
        bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge ref_clk_i);
        bus.rd <= 1'b0;
        #1 chk($sformatf("reg %h", a), {24'h0, exp}, {24'h0, rd_data});
    endtask
    // Waits, with a bound, for n far-side bit times, then lets the word land.
    task waitc(input logic [5:0] n, input bit rx);
        for (int k = 0; k < 400 && (rx ? ridx : cnt) < n; k++) @(posedge ref_clk_i);
        repeat (12) @(posedge ref_clk_i);
    endtask
    // Counts shift clock rises over 24 cycles and the last rise-to-rise gap.
    task scan;
        int t0;
        r = 0;
        p = 0;
        t0 = 0;
        ckl = ck_o;
        for (int i = 0; i < 24; i++) begin
            @(posedge ref_clk_i);
            #1;
            if (ck_o && !ckl) begin
                p = i - t0;
                t0 = i;
                r++;
            end
            ckl = ck_o;
        end
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // The whole run is far below this span; a hang ends here.
    initial begin
        #2000000;
        n_fail++;
        tally_and_finish;
    end
    // ------------------------------------------------------------
    // Test sequence.
    // ------------------------------------------------------------
    initial begin
        bus = '0;
        rst_i = 1'b1;
        {want, slave, go, clr, dt_last} = 5'b00010;
        pat = 32'h0;
        n_fail = 0;
        checked = 0;
        repeat (12) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        clr <= 1'b0;
        for (int i = 0; i < 8; i++) rd(ra[i], rv[i]);
        wr(8'h8c, 8'hff);
        rd(8'h8c, 8'hff);
        wr(8'h8c, 8'h10);
        wr(8'h99, 8'h03);
        wr(8'h18, 8'h80);
        wr(8'h98, 8'h90);
        scan();
        chk("idle rises", 0, r);
        wr(8'h19, 8'ha5);
        wr(8'h98, 8'hb0);
        wr(8'h19, 8'h3c);
        rd(8'h0c, 8'h00);
        chk("irq held", 0, {31'h0, irq});
        rd(8'h98, 8'hb0);
        waitc(6'd16, 1'b0);
        chk("tx words", 32'h3ca5, {16'h0, cap[15:0]});
        rd(8'h98, 8'hb2);
        rd(8'h0c, 8'h10);
        chk("irq raised", 1, {31'h0, irq});
        wr(8'h0c, 8'h00);
        rd(8'h0c, 8'h10);
        scan();
        chk("period", 8, p);
        rd(8'h98, 8'hb2);
        wr(8'h98, 8'hd1);
        clr <= 1'b1;
        wr(8'h19, 8'h5a);
        clr <= 1'b0;
        wr(8'h98, 8'hf1);
        wr(8'h98, 8'hf0);
        wr(8'h19, 8'h81);
        waitc(6'd18, 1'b0);
        chk("ninth words", 32'h1035a, {14'h0, cap[17:0]});
        wr(8'h19, 8'hff);
        repeat (20) @(posedge ref_clk_i);
        wr(8'h98, 8'hd0);
        #1 chk("abort pins", 0, {30'h0, ck_oe, dt_oe});
        rd(8'h98, 8'hd2);
        scan();
        chk("stopped rises", 0, r);
        wr(8'h98, 8'hb0);
        wr(8'h19, 8'h0f);
        repeat (20) @(posedge ref_clk_i);
        pat <= 32'h000000c3;
        want <= 1'b1;
        wr(8'h18, 8'ha0);
        #1 chk("rx pins", 2, {30'h0, ck_oe, dt_oe});
        waitc(6'd8, 1'b1);
        rd(8'h18, 8'h80);
        chk("tx resumes", 1, {31'h0, dt_oe});
        rd(8'h0c, 8'h30);
        rd(8'h1a, 8'hc3);
        rd(8'h0c, 8'h10);
        want <= 1'b0;
        wr(8'h98, 8'h90);
        pat <= {5'h0, 9'h1ff, 9'h05a, 9'h1c3};
        want <= 1'b1;
        wr(8'h18, 8'hd0);
        waitc(6'd27, 1'b1);
        rd(8'h18, 8'hd3);
        rd(8'h1a, 8'hc3);
        rd(8'h18, 8'hd2);
        rd(8'h1a, 8'h5a);
        repeat (80) @(posedge ref_clk_i);
        rd(8'h0c, 8'h00);
        wr(8'h18, 8'hc0);
        rd(8'h18, 8'hc1);
        want <= 1'b0;
        wr(8'h98, 8'h10);
        slave <= 1'b1;
        want <= 1'b1;
        pat <= 32'h00000096;
        wr(8'h18, 8'h90);
        #1 chk("slave clock pin", 0, {31'h0, ck_oe});
        go <= 1'b1;
        waitc(6'd8, 1'b1);
        go <= 1'b0;
        rd(8'h1a, 8'h96);
        tally_and_finish;
    end
endmodule
